/* File: ofm_defs.vh */
// shared constants of the oscillator frequency range monitor
`ifndef OFM_DEFS_VH
`define OFM_DEFS_VH

// register indexes on the plain register port
`define OFM_AW              3
`define OFM_ADDR_LOW        3'h0
`define OFM_ADDR_HIGH       3'h1
`define OFM_ADDR_KEY        3'h2
`define OFM_ADDR_CTRL       3'h3
`define OFM_ADDR_STATUS     3'h4
`define OFM_ADDR_COUNT      3'h5

// reset values after the external reset pin
`define OFM_LOW_RST         8'h20
`define OFM_HIGH_RST        8'h40
`define OFM_KEY_RST         8'h06
`define OFM_CTRL_RST        8'h00

// key and control codes
`define OFM_KEY_UNLOCK      8'hF9
`define OFM_KEY_LOCK        8'h06
`define OFM_CTRL_ON         8'hE4
`define OFM_CTRL_OFF        8'h00

// status register bit positions
`define OFM_ST_ACTIVE       0
`define OFM_ST_TOO_LOW      1
`define OFM_ST_TOO_HIGH     2
`define OFM_ST_IO_RST       3
`define OFM_ST_STOPPED      4

// timing: reference period, gate window and fault persistence, in ns
`define OFM_CLK_NS          40
`define OFM_WIN_NS          12800
`define OFM_PERSIST_NS      51200
`define OFM_WIN_CYC         (`OFM_WIN_NS / `OFM_CLK_NS)
`define OFM_PERSIST_WIN     (`OFM_PERSIST_NS / `OFM_WIN_NS)

// counter widths and saturation value
`define OFM_WCW             9
`define OFM_PCW             3
`define OFM_CNT_MAX         8'hFF
`define OFM_ZERO8           8'h00

`endif

/* File: ofm_freq_meter.v */
// gate-window edge counter for the divided oscillator input
`timescale 1ns/1ns
`include "ofm_defs.vh"

module ofm_freq_meter (
   ref_clk,
   rst_n,
   osc_div_pin,
   win_done,
   win_count
);
   input  wire       ref_clk;
   input  wire       rst_n;
   input  wire       osc_div_pin;
   output reg        win_done;
   output reg  [7:0] win_count;

   localparam integer        WIN_LAST_I = `OFM_WIN_CYC - 1;
   localparam [`OFM_WCW-1:0] WIN_LAST   = WIN_LAST_I[`OFM_WCW-1:0];

   reg                sync1_reg;
   reg                sync2_reg;
   reg                prev_reg;
   reg [`OFM_WCW-1:0] gate_reg;
   reg [7:0]          edge_cnt_reg;
   wire               rise;
   wire               gate_end;

   // the pin is asynchronous to ref_clk; the edge detector reads stage two only
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         prev_reg  <= 1'b0;
      end else begin
         sync1_reg <= osc_div_pin;
         sync2_reg <= sync1_reg;
         prev_reg  <= sync2_reg;
      end
   end

   assign rise     = sync2_reg & ~prev_reg;
   assign gate_end = (gate_reg == WIN_LAST);

   // fixed gate timed by ref_clk; the count saturates so a runaway clock still reads high
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         gate_reg     <= {`OFM_WCW{1'b0}};
         edge_cnt_reg <= `OFM_ZERO8;
         win_done     <= 1'b0;
         win_count    <= `OFM_ZERO8;
      end else begin
         win_done <= gate_end;
         if (gate_end) begin
            gate_reg     <= {`OFM_WCW{1'b0}};
            edge_cnt_reg <= `OFM_ZERO8;
            win_count    <= (rise && edge_cnt_reg != `OFM_CNT_MAX) ?
                            edge_cnt_reg + 8'h01 : edge_cnt_reg;
         end else begin
            gate_reg <= gate_reg + {{(`OFM_WCW-1){1'b0}}, 1'b1};
            if (rise && edge_cnt_reg != `OFM_CNT_MAX)
               edge_cnt_reg <= edge_cnt_reg + 8'h01;
         end
      end
   end

endmodule

/* File: ofm_monitor.v */
// oscillator frequency range monitor: key-guarded registers, persistence filter, I/O reset
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`include "ofm_defs.vh"

module ofm_monitor (
   ref_clk,
   rst_n,
   reg_addr,
   reg_wdata,
   reg_wr,
   reg_rd,
   reg_rdata,
   osc_div_pin,
   stop_mode,
   warmup_active,
   serial_prog_mode,
   io_hiz,
   core_rst,
   det_active
);
   input  wire                ref_clk;
   input  wire                rst_n;
   input  wire [`OFM_AW-1:0]  reg_addr;
   input  wire [7:0]          reg_wdata;
   input  wire                reg_wr;
   input  wire                reg_rd;
   output wire [7:0]          reg_rdata;
   input  wire                osc_div_pin;
   input  wire                stop_mode;
   input  wire                warmup_active;
   input  wire                serial_prog_mode;
   output wire                io_hiz;
   output wire                core_rst;
   output wire                det_active;

   // persistence counted in whole windows; the counter starts at zero, so it ends one short of the span
   localparam integer        PERSIST_LAST_I = `OFM_PERSIST_WIN - 1;
   localparam [`OFM_PCW-1:0] PERSIST_LAST   = PERSIST_LAST_I[`OFM_PCW-1:0];
   localparam [`OFM_PCW-1:0] PCNT_ZERO    = {`OFM_PCW{1'b0}};
   localparam [`OFM_PCW-1:0] PCNT_ONE     = {{(`OFM_PCW-1){1'b0}}, 1'b1};

   // filter states
   localparam [1:0] ST_IDLE  = 2'b00;
   localparam [1:0] ST_OK    = 2'b01;
   localparam [1:0] ST_FAULT = 2'b10;

   // register file, held only by the external reset pin
   reg [7:0]          low_freq_limit_reg;
   reg [7:0]          high_freq_limit_reg;
   reg [7:0]          detect_write_key_reg;
   reg [7:0]          detect_enable_ctrl_reg;
   reg [7:0]          rdata_reg;
   reg [7:0]          rdata_next;

   // mode pins, synchronised
   reg                stop_s1_reg;
   reg                stop_s2_reg;
   reg                warm_s1_reg;
   reg                warm_s2_reg;
   reg                prog_s1_reg;
   reg                prog_s2_reg;

   // filter
   reg [1:0]          state_reg;
   reg [1:0]          state_next;
   reg [`OFM_PCW-1:0] pcnt_reg;
   reg [`OFM_PCW-1:0] pcnt_next;
   reg                too_low_reg;
   reg                too_high_reg;
   reg                stopped_reg;
   reg [7:0]          last_count_reg;

   // outputs
   reg                io_hiz_reg;
   reg                core_rst_reg;
   reg                det_active_reg;

   // window result, write enables and the range verdict
   wire               win_done;
   wire [7:0]         win_count;
   wire               unlocked;
   wire               enabled;
   wire               allowed;
   wire               wr_low;
   wire               wr_high;
   wire               wr_key;
   wire               wr_ctrl;
   wire               bad;

   // address match, used by the write decoder only; the read mux decodes with its own case
   function hit;
      input [`OFM_AW-1:0] addr;
      input [`OFM_AW-1:0] idx;
      begin
         hit = (addr == idx);
      end
   endfunction

   ofm_freq_meter u_meter (
      .ref_clk     (ref_clk),
      .rst_n       (rst_n),
      .osc_div_pin (osc_div_pin),
      .win_done    (win_done),
      .win_count   (win_count)
   );

   // mode inputs come from another part of the chip, possibly another clock
   // trade-off: two cycles of lag on every mode change, in exchange for no metastable enable
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         stop_s1_reg <= 1'b0;
         stop_s2_reg <= 1'b0;
         warm_s1_reg <= 1'b0;
         warm_s2_reg <= 1'b0;
         prog_s1_reg <= 1'b0;
         prog_s2_reg <= 1'b0;
      end else begin
         stop_s1_reg <= stop_mode;
         stop_s2_reg <= stop_s1_reg;
         warm_s1_reg <= warmup_active;
         warm_s2_reg <= warm_s1_reg;
         prog_s1_reg <= serial_prog_mode;
         prog_s2_reg <= prog_s1_reg;
      end
   end

   // write guards
   // a limit write needs the key open and detection off; control needs the key only
   assign unlocked = (detect_write_key_reg == `OFM_KEY_UNLOCK);
   assign enabled  = (detect_enable_ctrl_reg == `OFM_CTRL_ON);
   assign wr_key   = reg_wr && hit(reg_addr, `OFM_ADDR_KEY);
   assign wr_ctrl  = reg_wr && hit(reg_addr, `OFM_ADDR_CTRL) && unlocked;
   assign wr_low   = reg_wr && hit(reg_addr, `OFM_ADDR_LOW) && unlocked && !enabled;
   assign wr_high  = reg_wr && hit(reg_addr, `OFM_ADDR_HIGH) && unlocked && !enabled;

   // detection runs only when enabled in NORMAL or IDLE, not in STOP, warm-up or flash mode
   assign allowed = enabled && !stop_s2_reg && !warm_s2_reg && !prog_s2_reg;

   // a zero count means the oscillator is not toggling at all
   // a count equal to either limit is still in range
   assign bad = (win_count < low_freq_limit_reg) ||
                (win_count > high_freq_limit_reg);

   // guarded registers; no internal reset input exists, so only rst_n reloads them
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         low_freq_limit_reg     <= `OFM_LOW_RST;
         high_freq_limit_reg    <= `OFM_HIGH_RST;
         detect_write_key_reg   <= `OFM_KEY_RST;
         detect_enable_ctrl_reg <= `OFM_CTRL_RST;
      end else begin
         if (wr_low)
            low_freq_limit_reg <= reg_wdata;
         if (wr_high)
            high_freq_limit_reg <= reg_wdata;
         if (wr_key)
            detect_write_key_reg <= reg_wdata;
         if (wr_ctrl)
            detect_enable_ctrl_reg <= reg_wdata;
      end
   end

   // read mux; everything is readable whatever the key holds
   // unmapped indexes and unused status bits read as zero
   always @* begin
      rdata_next = `OFM_ZERO8;
      if (reg_rd) begin
         case (reg_addr)
            `OFM_ADDR_LOW:    rdata_next = low_freq_limit_reg;
            `OFM_ADDR_HIGH:   rdata_next = high_freq_limit_reg;
            `OFM_ADDR_KEY:    rdata_next = detect_write_key_reg;
            `OFM_ADDR_CTRL:   rdata_next = detect_enable_ctrl_reg;
            `OFM_ADDR_STATUS: begin
               rdata_next[`OFM_ST_ACTIVE]   = det_active_reg;
               rdata_next[`OFM_ST_TOO_LOW]  = too_low_reg;
               rdata_next[`OFM_ST_TOO_HIGH] = too_high_reg;
               rdata_next[`OFM_ST_IO_RST]   = io_hiz_reg;
               rdata_next[`OFM_ST_STOPPED]  = stopped_reg;
            end
            `OFM_ADDR_COUNT:  rdata_next = last_count_reg;
            default:          rdata_next = `OFM_ZERO8;
         endcase
      end
   end

   // read data stands only in the cycle after the strobe
   always @(posedge ref_clk) begin
      if (!rst_n)
         rdata_reg <= `OFM_ZERO8;
      else
         rdata_reg <= rdata_next;
   end

   // persistence filter: a run of bad windows sets, a run of good windows clears
   always @* begin
      state_next = state_reg;
      pcnt_next  = pcnt_reg;
      case (state_reg)
         ST_IDLE: begin
            // wait for a window edge, so the first window judged is a full one and a
            // partial window right after enabling cannot shorten the persistence span
            pcnt_next = PCNT_ZERO;
            if (allowed && win_done)
               state_next = ST_OK;
         end
         ST_OK: begin
            if (!allowed) begin
               state_next = ST_IDLE;
               pcnt_next  = PCNT_ZERO;
            end else if (win_done) begin
               if (!bad)
                  pcnt_next = PCNT_ZERO;
               else if (pcnt_reg == PERSIST_LAST) begin
                  state_next = ST_FAULT;
                  pcnt_next  = PCNT_ZERO;
               end else
                  pcnt_next = pcnt_reg + PCNT_ONE;
            end
         end
         ST_FAULT: begin
            // in fault the same counter runs on good windows toward release
            if (!allowed) begin
               state_next = ST_IDLE;
               pcnt_next  = PCNT_ZERO;
            end else if (win_done) begin
               if (bad)
                  pcnt_next = PCNT_ZERO;
               else if (pcnt_reg == PERSIST_LAST) begin
                  state_next = ST_OK;
                  pcnt_next  = PCNT_ZERO;
               end else
                  pcnt_next = pcnt_reg + PCNT_ONE;
            end
         end
         default: begin
            state_next = ST_IDLE;
            pcnt_next  = PCNT_ZERO;
         end
      endcase
   end

   // filter state and the latest measurement
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         state_reg      <= ST_IDLE;
         pcnt_reg       <= PCNT_ZERO;
         too_low_reg    <= 1'b0;
         too_high_reg   <= 1'b0;
         stopped_reg    <= 1'b0;
         last_count_reg <= `OFM_ZERO8;
      end else begin
         state_reg <= state_next;
         pcnt_reg  <= pcnt_next;
         if (win_done) begin
            last_count_reg <= win_count;
            too_low_reg    <= (win_count < low_freq_limit_reg);
            too_high_reg   <= (win_count > high_freq_limit_reg);
            stopped_reg    <= (win_count == `OFM_ZERO8);
         end
      end
   end

   // outputs from flops; the core is not reset when the fault is a dead oscillator,
   // since in silicon its reset would be clocked by that same missing clock
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         io_hiz_reg     <= 1'b0;
         core_rst_reg   <= 1'b0;
         det_active_reg <= 1'b0;
      end else begin
         io_hiz_reg     <= (state_next == ST_FAULT);
         core_rst_reg   <= (state_next == ST_FAULT) && !stopped_reg;
         det_active_reg <= allowed;
      end
   end

   // top outputs are plain copies of flops, so no glitch reaches the pins
   assign reg_rdata  = rdata_reg;
   assign io_hiz     = io_hiz_reg;
   assign core_rst   = core_rst_reg;
   assign det_active = det_active_reg;

endmodule

/* File: ofm_osc_model.sv */
// behavioural source of the divided high-frequency oscillator input
`timescale 1ns/1ns

module ofm_osc_model (
   input  wire  run,
   input  int   half_ns,
   output logic osc_div_pin
);
   initial osc_div_pin = 1'b0;

   // a stopped crystal parks the pin at its last level; nothing toggles it
   always begin
      #(half_ns);
      if (run) osc_div_pin = ~osc_div_pin;
   end
endmodule

/* File: ofm_monitor_asserts.sv */
// concurrent checks on the ports of the frequency range monitor
`timescale 1ns/1ns
`include "ofm_defs.vh"

module ofm_monitor_asserts (
   input wire               ref_clk,
   input wire               rst_n,
   input wire [`OFM_AW-1:0] reg_addr,
   input wire [7:0]         reg_wdata,
   input wire               reg_wr,
   input wire               reg_rd,
   input wire [7:0]         reg_rdata,
   input wire               osc_div_pin,
   input wire               stop_mode,
   input wire               warmup_active,
   input wire               serial_prog_mode,
   input wire               io_hiz,
   input wire               core_rst,
   input wire               det_active
);
   logic [7:0] sh [0:3];
   logic [7:0] exp_rd;
   int         act_cnt;

   // shadows follow the key guard so every read of indexes 0 to 3 can be predicted
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         sh[0] <= `OFM_LOW_RST;
         sh[1] <= `OFM_HIGH_RST;
         sh[2] <= `OFM_KEY_RST;
         sh[3] <= `OFM_CTRL_RST;
      end else if (reg_wr) begin
         if (reg_addr == `OFM_ADDR_KEY) sh[2] <= reg_wdata;
         if (reg_addr == `OFM_ADDR_CTRL && sh[2] == `OFM_KEY_UNLOCK) sh[3] <= reg_wdata;
         if (reg_addr < 3'h2 && sh[2] == `OFM_KEY_UNLOCK && sh[3] != `OFM_CTRL_ON) sh[reg_addr[0]] <= reg_wdata;
      end
   end

   always @(posedge ref_clk) exp_rd <= sh[reg_addr[1:0]];

   // run length of detection, saturated well past one persistence span
   always @(posedge ref_clk) begin
      if (!rst_n || !det_active) act_cnt <= 0;
      else if (act_cnt < 4000) act_cnt <= act_cnt + 1;
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence rd_req;
      reg_rd && reg_addr < 3'h4;
   endsequence
   sequence quiet_on;
      sh[3] == `OFM_CTRL_ON && !stop_mode && !warmup_active && !serial_prog_mode;
   endsequence

   rd_value_a: assert property (rd_req |=> reg_rdata == exp_rd)
      else $error("register read returned a wrong value");
   rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not idle outside the read slot");
   det_on_a: assert property (quiet_on [*7] |-> det_active)
      else $error("detection not running while enabled");
   det_off_a: assert property ((sh[3] != `OFM_CTRL_ON) [*5] |-> !det_active)
      else $error("detection running while control is off");
   stop_off_a: assert property ((stop_mode || warmup_active) [*5] |-> !det_active)
      else $error("detection running in stop or warm-up");
   serial_off_a: assert property (serial_prog_mode [*5] |-> !det_active)
      else $error("detection running in serial programming");
   hiz_gated_a: assert property ((!det_active) [*5] |-> !io_hiz)
      else $error("pins floated while detection is off");
   core_gated_a: assert property (core_rst |-> io_hiz)
      else $error("core reset without detection reset");
   persist_a: assert property ($rose(io_hiz) |-> act_cnt >= `OFM_PERSIST_NS / `OFM_CLK_NS)
      else $error("detection reset raised before persistence time");
endmodule

bind ofm_monitor ofm_monitor_asserts ofm_monitor_asserts_inst (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .osc_div_pin, .stop_mode, .warmup_active, .serial_prog_mode, .io_hiz, .core_rst, .det_active);

/* File: ofm_monitor_bench.sv */
// self-checking bench of the frequency range monitor
`timescale 1ns/1ns
`include "ofm_defs.vh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
   $display("[ERR] %s expected %h seen %h", nm, e, g); end end

module ofm_monitor_bench;
   logic               ref_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, osc_run = 1;
   logic               stop_mode = 0, warmup_active = 0, serial_prog_mode = 0;
   logic [`OFM_AW-1:0] reg_addr = 0;
   logic [7:0]         reg_wdata = 0, lo, hi, st = 8'h00;
   logic [7:0]         m [0:3];
   wire  [7:0]         reg_rdata;
   wire                osc_div_pin, io_hiz, core_rst, det_active;
   int                 num_errors = 0, num_checks = 0, seed = 53431, half_ns = 128, i;

   ofm_monitor ofm_monitor_inst (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .osc_div_pin, .stop_mode, .warmup_active, .serial_prog_mode, .io_hiz, .core_rst, .det_active);
   ofm_osc_model ofm_osc_model_inst (.run(osc_run), .half_ns(half_ns), .osc_div_pin(osc_div_pin));

   always #20 ref_clk = ~ref_clk;

   function automatic logic pick(input int sel);
      return sel == 0 ? io_hiz : (sel == 1 ? det_active : core_rst);
   endfunction

   function automatic string nm(input int sel);
      return sel == 0 ? "io_hiz" : (sel == 1 ? "det_active" : "core_rst");
   endfunction

   // write strobe for one cycle; the model applies the same key guard
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1;
      @(posedge ref_clk);
      reg_wr <= 0;
      if (a < 3'h2) begin
         if (m[2] == `OFM_KEY_UNLOCK && m[3] != `OFM_CTRL_ON) m[a[0]] = d;
      end else if (a == 3'h2) m[2] = d;
      else if (a == 3'h3 && m[2] == `OFM_KEY_UNLOCK) m[3] = d;
   endtask

   // read strobe, data taken in the following cycle only
   task automatic rdchk(input logic [2:0] a);
      logic [7:0] e;
      e = a < 3'h4 ? m[a[1:0]] : (a == 3'h4 ? st : 8'h00);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1;
      @(posedge ref_clk);
      reg_rd <= 0;
      @(negedge ref_clk);
      `CHK("reg_rdata", e, reg_rdata)
   endtask

   // bounded wait for an output level
   task automatic waitv(input int sel, input logic e, input int lim);
      logic v;
      v = ~e;
      for (i = 0; i < lim && v !== e; i++) begin
         @(negedge ref_clk);
         v = pick(sel);
      end
      `CHK(nm(sel), e, v)
   endtask

   // an output must keep one level for the whole span
   task automatic holdv(input int sel, input logic e, input int cyc);
      logic v;
      v = e;
      for (i = 0; i < cyc; i++) begin
         @(negedge ref_clk);
         if (pick(sel) !== e) v = pick(sel);
      end
      `CHK(nm(sel), e, v)
   endtask

   task automatic do_reset();
      @(posedge ref_clk);
      rst_n <= 0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1;
      m = '{`OFM_LOW_RST, `OFM_HIGH_RST, `OFM_KEY_RST, `OFM_CTRL_RST};
   endtask

   task automatic summarize();
      if (num_errors == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // about 11k cycles are needed; the limit leaves ample margin
   initial begin
      #(40 * 60000);
      num_errors++;
      summarize();
   end

   initial begin
      do_reset();
      for (int k = 0; k < 4; k++) rdchk(k[2:0]);
      rdchk(3'h6);
      wr(3'h6, 8'h5A);
      wr(3'h3, `OFM_CTRL_ON);
      wr(3'h0, 8'h11);
      rdchk(3'h3);
      rdchk(3'h0);
      // legal limits around a 50-count oscillator: low below high, both within 8 to 20 MHz
      lo = 8'h1A + ($random(seed) & 8'h0F);
      hi = 8'h34 + ($random(seed) & 8'h07);
      wr(3'h2, `OFM_KEY_UNLOCK);
      wr(3'h0, lo);
      wr(3'h1, hi);
      rdchk(3'h0);
      rdchk(3'h1);
      wr(3'h3, `OFM_CTRL_ON);
      waitv(1, 1, 8);
      wr(3'h0, 8'h01);
      wr(3'h2, `OFM_KEY_LOCK);
      rdchk(3'h0);
      rdchk(3'h1);
      rdchk(3'h3);
      holdv(0, 0, 1600);
      half_ns = 400;
      repeat (640) @(posedge ref_clk);
      half_ns = 128;
      holdv(0, 0, 1600);
      half_ns = 400;
      waitv(0, 1, 2000);
      holdv(2, 1, 4);
      for (int k = 0; k < 4; k++) rdchk(k[2:0]);
      half_ns = 128;
      waitv(0, 0, 2000);
      half_ns = 50;
      waitv(0, 1, 2000);
      half_ns = 128;
      waitv(0, 0, 2000);
      osc_run = 0;
      waitv(0, 1, 2000);
      holdv(2, 0, 20);
      st = 8'h1B; // active, too low, pins floated, stopped
      rdchk(3'h4);
      rdchk(3'h5);
      @(posedge ref_clk);
      stop_mode <= 1;
      waitv(1, 0, 8);
      waitv(0, 0, 8);
      osc_run = 1;
      @(posedge ref_clk);
      stop_mode <= 0;
      warmup_active <= 1;
      holdv(1, 0, 20);
      @(posedge ref_clk);
      warmup_active <= 0;
      waitv(1, 1, 8);
      @(posedge ref_clk);
      serial_prog_mode <= 1;
      waitv(1, 0, 8);
      @(posedge ref_clk);
      serial_prog_mode <= 0;
      waitv(1, 1, 8);
      wr(3'h2, `OFM_KEY_UNLOCK);
      wr(3'h3, `OFM_CTRL_OFF);
      waitv(1, 0, 8);
      rdchk(3'h3);
      wr(3'h0, 8'h22);
      rdchk(3'h0);
      do_reset();
      for (int k = 0; k < 4; k++) rdchk(k[2:0]);
      summarize();
   end
endmodule
